// ==== hw/servo_drive_io_sequencer.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Servo enable energises motor; release otherwise
// R2: Pole setting A/B runs estimation first
// R3: Fault clear edge cancels latched alarm
// R4: Host drops enable, fixes fault first
// R5: Torque cap input applies configured limit
// R6: Forward limit low blocks forward motion
// R7: Reverse limit low blocks reverse motion
// R8: Home switch ends the homing search
// R9: Homing request edge starts homing
// R10: Pulses counted only while gate high
// R11: Deviation clear zeroes position error
// R12: Ready needs main power, no alarm
// R13: Alarm output high normal, low faulted
// R14: Settled when error within window
// R15: Homing done after successful homing
// R16: Brake release while servo enabled
// R17: Two monitor channels, selectable quantity
// R18: Pulse format selectable, three kinds
// R19: Inputs synchronised, actions on rising edge
module servo_drive_io_sequencer
  import servo_io_pkg::*;
#(
  parameter int POLE_CYCLES = POLE_EST_CYCLES,
  parameter int MON_W       = 16
) (
  input  wire logic              aclk,                      // Clock
  input  wire logic              aresetn,                   // Sync reset, low
  input  wire logic [7:0]        s_axi_awaddr,              // Write address
  input  wire logic              s_axi_awvalid,             // Write address valid
  output logic                   s_axi_awready,             // Write address ready
  input  wire logic [31:0]       s_axi_wdata,               // Write data
  input  wire logic [3:0]        s_axi_wstrb,               // Byte enables
  input  wire logic              s_axi_wvalid,              // Write data valid
  output logic                   s_axi_wready,              // Write data ready
  output logic [1:0]             s_axi_bresp,               // Write response
  output logic                   s_axi_bvalid,              // Write response valid
  input  wire logic              s_axi_bready,              // Write response ready
  input  wire logic [7:0]        s_axi_araddr,              // Read address
  input  wire logic              s_axi_arvalid,             // Read address valid
  output logic                   s_axi_arready,             // Read address ready
  output logic [31:0]            s_axi_rdata,               // Read data
  output logic [1:0]             s_axi_rresp,               // Read response
  output logic                   s_axi_rvalid,              // Read data valid
  input  wire logic              s_axi_rready,              // Read data ready
  input  wire logic              servo_enable_in,           // Servo enable pin
  input  wire logic              fault_clear_in,            // Alarm reset pin
  input  wire logic              torque_cap_in,             // Torque limit pin
  input  wire logic              fwd_limit_in,              // Forward limit, low blocks
  input  wire logic              rev_limit_in,              // Reverse limit, low blocks
  input  wire logic              home_switch_in,            // Origin area sensor
  input  wire logic              homing_request_in,         // Start homing pin
  input  wire logic              pulse_cmd_gate_in,         // Pulse input enable
  input  wire logic              deviation_clear_in,        // Error counter clear
  input  wire logic              main_power_in,             // Main power present
  input  wire logic              fault_event_in,            // Power stage fault
  input  wire logic              pulse_a_in,                // Pulse / fwd / phase A
  input  wire logic              pulse_b_in,                // Dir / rev / phase B
  input  wire logic [31:0]       actual_pos_in,             // Encoder position
  input  wire logic [15:0]       speed_in,                  // Detected speed
  input  wire logic [15:0]       torque_cmd_in,             // Loop torque demand
  output logic                   motor_energise_out,        // Power stage on
  output logic                   pole_estimating_out,       // Pole estimation active
  output logic                   home_seek_out,             // Homing search motion
  output logic [15:0]            torque_cmd_out,            // Limited torque demand
  output logic                   fwd_inhibit_out,           // Forward motion blocked
  output logic                   rev_inhibit_out,           // Reverse motion blocked
  output logic [31:0]            cmd_pos_out,               // Commanded position
  output logic                   drive_ready_out,           // Servo ready
  output logic                   fault_ok_out,              // Alarm, low when faulted
  output logic                   settled_out,               // In position
  output logic                   homing_done_out,           // Homing complete
  output logic                   holding_brake_release_out, // Brake release
  output logic [MON_W-1:0]       monitor_channel_one,       // Monitor 1
  output logic [MON_W-1:0]       monitor_channel_two,       // Monitor 2
  output logic                   irq_out                    // Level interrupt
);

  localparam int NIN = $bits(io_in_t);

  // Elaboration checks
  if (POLE_CYCLES < 1) begin : g_bad_pole
    $error("POLE_CYCLES must be at least 1");
  end
  if (MON_W < 1 || MON_W > 16) begin : g_bad_mon
    $error("MON_W must be 1 to 16");
  end

  // Quadrature step: +1, -1 or 0 from old and new phases
  function automatic logic [1:0] quad_step(input logic [1:0] o, input logic [1:0] n);
    logic [3:0] t;
    t = {o, n};
    case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b11;
      default: quad_step = 2'b00;
    endcase
  endfunction

  // Three-stage synchroniser, change taken when stages two and three agree
  io_in_t raw, s1, s2, s3, pin, pin_d;
  assign raw = '{servo_enable_in, fault_clear_in, torque_cap_in, fwd_limit_in,
                 rev_limit_in, home_switch_in, homing_request_in, pulse_cmd_gate_in,
                 deviation_clear_in, main_power_in, fault_event_in, pulse_a_in, pulse_b_in};
  for (genvar i = 0; i < NIN; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1[i]    <= 1'b0;
        s2[i]    <= 1'b0;
        s3[i]    <= 1'b0;
        pin[i]   <= 1'b0;
        pin_d[i] <= 1'b0;
      end else begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          pin[i] <= s3[i]; // R19
        end
        pin_d[i] <= pin[i];
      end
    end
  end
  io_in_t rise;
  assign rise = pin & ~pin_d; // R19

  // Registers
  logic [31:0]         config_reg;
  logic [15:0]         tq_limit;
  logic [15:0]         in_pos_win;
  logic [IRQ_BITS-1:0] irq_stat;
  logic [IRQ_BITS-1:0] irq_en;
  logic                alarm;
  servo_state_t        servo_st;
  home_state_t         home_st;
  logic [31:0]         pole_cnt;
  logic [31:0]         cmd_pos;
  logic [31:0]         pos_err;
  logic [31:0]         abs_err;
  logic                settled_d;

  logic [1:0] pole_sel;
  pulse_fmt_t fmt;
  mon_sel_t   mon1_sel, mon2_sel;
  assign pole_sel = config_reg[CFG_POLE_LSB +: 2];
  assign mon1_sel = mon_sel_t'(config_reg[CFG_MON1_LSB +: 2]);
  assign mon2_sel = mon_sel_t'(config_reg[CFG_MON2_LSB +: 2]);
  assign fmt      = pulse_fmt_t'(config_reg[CFG_FMT_LSB +: 2]);

  // AXI write channel: address and data taken in either order
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        irq_clr_wr;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign irq_clr_wr    = do_write && aw_addr == ADDR_IRQ_CLR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == ADDR_CONFIG || aw_addr == ADDR_TQ_LIMIT || aw_addr == ADDR_IN_POS ||
            aw_addr == ADDR_IRQ_CLR || aw_addr == ADDR_IRQ_EN) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers with byte enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= RST_CONFIG;
      tq_limit   <= RST_TQ_LIMIT;
      in_pos_win <= RST_IN_POS;
      irq_en     <= '0;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b] && aw_addr == ADDR_CONFIG) begin
          config_reg[8*b +: 8] <= w_data[8*b +: 8];
        end
      end
      if (aw_addr == ADDR_TQ_LIMIT) begin
        if (w_strb[0]) tq_limit[7:0]  <= w_data[7:0];
        if (w_strb[1]) tq_limit[15:8] <= w_data[15:8];
      end else if (aw_addr == ADDR_IN_POS) begin
        if (w_strb[0]) in_pos_win[7:0]  <= w_data[7:0];
        if (w_strb[1]) in_pos_win[15:8] <= w_data[15:8];
      end else if (aw_addr == ADDR_IRQ_EN && w_strb[0]) begin
        irq_en <= w_data[IRQ_BITS-1:0];
      end
    end
  end

  // AXI read channel, data one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CONFIG) begin
        s_axi_rdata <= config_reg;
      end else if (s_axi_araddr == ADDR_TQ_LIMIT) begin
        s_axi_rdata <= {16'h0000, tq_limit};
      end else if (s_axi_araddr == ADDR_IN_POS) begin
        s_axi_rdata <= {16'h0000, in_pos_win};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata <= {22'h000000, home_st, servo_st, settled_out, alarm, drive_ready_out,
                        pin.main_power};
      end else if (s_axi_araddr == ADDR_POS_ERR) begin
        s_axi_rdata <= pos_err;
      end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
        s_axi_rdata <= {{(32-IRQ_BITS){1'b0}}, irq_stat};
      end else if (s_axi_araddr == ADDR_IRQ_EN) begin
        s_axi_rdata <= {{(32-IRQ_BITS){1'b0}}, irq_en};
      end else if (s_axi_araddr == ADDR_IRQ_CLR) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Alarm latch, a new fault wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm <= 1'b0;
    end else if (rise.fault_event) begin
      alarm <= 1'b1;
    end else if (rise.fault_clear) begin
      alarm <= 1'b0; // R3
    end
  end
  assign fault_ok_out    = !alarm;                   // R13
  assign drive_ready_out = pin.main_power && !alarm; // R12

  // Servo sequence with optional pole estimation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      servo_st <= S_OFF;
      pole_cnt <= 32'h0000_0000;
    end else begin
      case (servo_st)
        S_OFF: begin
          pole_cnt <= 32'h0000_0000;
          if (pin.servo_enable && drive_ready_out) begin
            if (pole_sel == POLE_SET_A || pole_sel == POLE_SET_B) begin
              servo_st <= S_POLE; // R2
            end else begin
              servo_st <= S_RUN; // R1
            end
          end
        end
        S_POLE: begin
          pole_cnt <= pole_cnt + 32'h0000_0001;
          if (!pin.servo_enable || !drive_ready_out) begin
            servo_st <= S_OFF;
          end else if (pole_cnt == 32'(POLE_CYCLES - 1)) begin
            servo_st <= S_RUN; // R2
          end
        end
        S_RUN: begin
          if (!pin.servo_enable || !drive_ready_out) begin
            servo_st <= S_OFF; // R1
          end
        end
        default: servo_st <= S_OFF;
      endcase
    end
  end
  assign motor_energise_out        = servo_st != S_OFF; // R1
  assign holding_brake_release_out = servo_st != S_OFF; // R16
  assign pole_estimating_out       = servo_st == S_POLE;

  // Homing: search toward origin area until the switch shows it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      home_st <= H_IDLE;
    end else if (servo_st != S_RUN) begin
      home_st <= H_IDLE;
    end else begin
      case (home_st)
        H_IDLE: if (rise.homing_request) home_st <= H_SEEK; // R9
        H_SEEK: if (pin.home_switch) home_st <= H_DONE;     // R8
        H_DONE: if (rise.homing_request) home_st <= H_SEEK; // R9
        default: home_st <= H_IDLE;
      endcase
    end
  end
  assign home_seek_out   = home_st == H_SEEK && pin.rev_limit;
  assign homing_done_out = home_st == H_DONE; // R15

  // Travel limits and torque cap
  assign fwd_inhibit_out = !pin.fwd_limit; // R6
  assign rev_inhibit_out = !pin.rev_limit; // R7
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      torque_cmd_out <= 16'h0000;
    end else if (servo_st != S_RUN) begin
      torque_cmd_out <= 16'h0000;
    end else if (pin.torque_cap && $signed(torque_cmd_in) > $signed(tq_limit)) begin
      torque_cmd_out <= tq_limit; // R5
    end else if (pin.torque_cap && $signed(torque_cmd_in) < -$signed(tq_limit)) begin
      torque_cmd_out <= 16'(-$signed(tq_limit)); // R5
    end else begin
      torque_cmd_out <= torque_cmd_in;
    end
  end

  // Pulse train decode into a signed step
  logic [1:0] step;
  always_comb begin
    step = 2'b00;
    case (fmt)
      FMT_PULSE_DIR: if (rise.pulse_a) step = pin.pulse_b ? 2'b11 : 2'b01; // R18
      FMT_FWD_REV: begin
        if (rise.pulse_a && !rise.pulse_b) step = 2'b01; // R18
        if (rise.pulse_b && !rise.pulse_a) step = 2'b11; // R18
      end
      FMT_QUAD: step = quad_step({pin_d.pulse_a, pin_d.pulse_b},
                                 {pin.pulse_a, pin.pulse_b}); // R18
      default: step = 2'b00;
    endcase
  end
  logic step_ok;
  assign step_ok = pin.pulse_gate && servo_st == S_RUN &&                  // R10
                   !(step == 2'b01 && fwd_inhibit_out) &&                  // R6
                   !(step == 2'b11 && rev_inhibit_out);                    // R7

  // Commanded position and deviation clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_pos <= 32'h0000_0000;
    end else if (rise.deviation_clear || servo_st != S_RUN) begin
      cmd_pos <= actual_pos_in; // R11
    end else if (step_ok) begin
      cmd_pos <= cmd_pos + {{30{step[1]}}, step}; // R10
    end
  end
  assign cmd_pos_out = cmd_pos;

  // Position error and in-position flag
  assign pos_err = cmd_pos - actual_pos_in;
  assign abs_err = pos_err[31] ? 32'(-$signed(pos_err)) : pos_err;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settled_out <= 1'b1; // Idle high, no settled event out of reset
      settled_d   <= 1'b1;
    end else begin
      settled_out <= abs_err <= {16'h0000, in_pos_win}; // R14
      settled_d   <= settled_out;
    end
  end

  // Monitor channels
  function automatic logic [MON_W-1:0] mon_pick(input mon_sel_t s, input logic [15:0] sp,
                                                input logic [15:0] tq, input logic [31:0] er,
                                                input logic [31:0] cp);
    case (s)
      MON_SPEED:  mon_pick = sp[15 -: MON_W];
      MON_TORQUE: mon_pick = tq[15 -: MON_W];
      MON_ERROR:  mon_pick = er[MON_W-1:0];
      default:    mon_pick = cp[MON_W-1:0];
    endcase
  endfunction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_channel_one <= '0;
      monitor_channel_two <= '0;
    end else begin
      monitor_channel_one <= mon_pick(mon1_sel, speed_in, torque_cmd_out, pos_err, cmd_pos); // R17
      monitor_channel_two <= mon_pick(mon2_sel, speed_in, torque_cmd_out, pos_err, cmd_pos); // R17
    end
  end

  // Sticky interrupt status, set wins over clear
  logic [IRQ_BITS-1:0] irq_ev;
  assign irq_ev[IRQ_ALARM]   = rise.fault_event && !alarm;
  assign irq_ev[IRQ_HOMED]   = home_st == H_SEEK && pin.home_switch && servo_st == S_RUN;
  assign irq_ev[IRQ_SETTLED] = settled_out && !settled_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(irq_clr_wr && w_strb[0] ? w_data[IRQ_BITS-1:0] : '0)) | irq_ev;
    end
  end
  assign irq_out = |(irq_stat & irq_en);

  // Checks
  a_brake_follows: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    !pin.servo_enable |=> !holding_brake_release_out) else $error("brake released while off");
  a_enable_starts: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    servo_st == S_OFF && pin.servo_enable && drive_ready_out && pole_sel == POLE_OFF
    |=> servo_st == S_RUN) else $error("servo did not start");
  a_pole_first: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    servo_st == S_OFF ##1 servo_st == S_RUN
    |-> $past(pole_sel) != POLE_SET_A && $past(pole_sel) != POLE_SET_B)
    else $error("run without pole estimate");
  a_alarm_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    alarm && rise.fault_clear && !rise.fault_event |=> fault_ok_out)
    else $error("alarm not cleared");
  a_alarm_low: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    rise.fault_event |=> !fault_ok_out && !drive_ready_out) else $error("alarm not set");
  a_ready_power: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    !pin.main_power |-> !drive_ready_out) else $error("ready without power");
  a_fwd_block: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    !pin.fwd_limit && !rise.deviation_clear && servo_st == S_RUN && $stable(servo_st)
    |=> $signed(cmd_pos - $past(cmd_pos)) <= 0) else $error("forward step past limit");
  a_gate_off: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    !pin.pulse_gate && !rise.deviation_clear && servo_st == S_RUN
    |=> $stable(cmd_pos)) else $error("pulse taken with gate off");
  a_dev_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    rise.deviation_clear |=> cmd_pos == $past(actual_pos_in))
    else $error("error not zeroed");
  a_home_done: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    home_st == H_SEEK && pin.home_switch && servo_st == S_RUN |=> homing_done_out)
    else $error("homing not done");
  a_settle_win: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    abs_err > {16'h0000, in_pos_win} |=> !settled_out) else $error("settled out of window");
  a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    $rose(s3.servo_enable) && s2.servo_enable |=> pin.servo_enable)
    else $error("sync filter late");

endmodule

// ==== hw/servo_io_pkg.sv ====
package servo_io_pkg;
  // Clock and pole estimation timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int POLE_EST_US     = 1000;
  localparam int POLE_EST_CYCLES = (POLE_EST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONFIG   = 8'h00;
  localparam logic [7:0] ADDR_TQ_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_IN_POS   = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_POS_ERR  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h1c;

  // Reset values
  localparam logic [31:0] RST_CONFIG   = 32'h0000_0000;
  localparam logic [15:0] RST_TQ_LIMIT = 16'h7fff;
  localparam logic [15:0] RST_IN_POS   = 16'h000a;

  // Config field positions
  localparam int CFG_POLE_LSB = 0;
  localparam int CFG_MON1_LSB = 2;
  localparam int CFG_MON2_LSB = 4;
  localparam int CFG_FMT_LSB  = 6;

  // Interrupt bit positions
  localparam int IRQ_ALARM   = 0;
  localparam int IRQ_HOMED   = 1;
  localparam int IRQ_SETTLED = 2;
  localparam int IRQ_BITS    = 3;

  // Pole estimation setting codes
  localparam logic [1:0] POLE_OFF   = 2'h0;
  localparam logic [1:0] POLE_SET_A = 2'h1;
  localparam logic [1:0] POLE_SET_B = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FMT_PULSE_DIR = 2'h0,
    FMT_FWD_REV   = 2'h1,
    FMT_QUAD      = 2'h2
  } pulse_fmt_t;

  typedef enum logic [1:0] {
    MON_SPEED  = 2'h0,
    MON_TORQUE = 2'h1,
    MON_ERROR  = 2'h2,
    MON_CMD    = 2'h3
  } mon_sel_t;

  typedef enum logic [2:0] {
    S_OFF  = 3'b001,
    S_POLE = 3'b010,
    S_RUN  = 3'b100
  } servo_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SEEK = 3'b010,
    H_DONE = 3'b100
  } home_state_t;

  // Discrete pin inputs, kept together through the synchroniser
  typedef struct packed {
    logic servo_enable;
    logic fault_clear;
    logic torque_cap;
    logic fwd_limit;
    logic rev_limit;
    logic home_switch;
    logic homing_request;
    logic pulse_gate;
    logic deviation_clear;
    logic main_power;
    logic fault_event;
    logic pulse_a;
    logic pulse_b;
  } io_in_t;
endpackage

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model
  import servo_io_pkg::*;
(
  input  wire logic   aclk, // Clock
  input  wire io_in_t want, // Requested pin levels
  output io_in_t      pins  // Levels on the drive pins
);
  // Alarm reset only goes out once servo enable is already off
  always_ff @(posedge aclk) begin
    pins             <= want;
    pins.fault_clear <= want.fault_clear && !pins.servo_enable;
  end
endmodule

// ==== testbench/servo_drive_io_sequencer_bench.sv ====
`timescale 1ns/1ps
module servo_drive_io_sequencer_bench;
  import servo_io_pkg::*;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, actual_pos_in = '0, cmd_pos_out, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] speed_in = '0, torque_cmd_in = '0, torque_cmd_out, monitor_channel_one;
  logic [15:0] monitor_channel_two;
  logic        s_axi_arready, s_axi_rvalid, irq_out, motor_energise_out, pole_estimating_out;
  logic        home_seek_out, fwd_inhibit_out, rev_inhibit_out, drive_ready_out, fault_ok_out;
  logic        settled_out, homing_done_out, holding_brake_release_out, servo_enable_in;
  logic        fault_clear_in, torque_cap_in, fwd_limit_in, rev_limit_in, home_switch_in;
  logic        homing_request_in, pulse_cmd_gate_in, deviation_clear_in, main_power_in;
  logic        fault_event_in, pulse_a_in, pulse_b_in;
  io_in_t      p = '0, want = '0, pins;
  int          err_total = 0, tests_run = 0;
  // Clock and pin fan-out
  always #50 aclk = ~aclk;
  assign {servo_enable_in, fault_clear_in, torque_cap_in, fwd_limit_in, rev_limit_in,
          home_switch_in, homing_request_in, pulse_cmd_gate_in, deviation_clear_in,
          main_power_in, fault_event_in, pulse_a_in, pulse_b_in} = pins;
  servo_drive_io_sequencer #(.POLE_CYCLES(8)) servo_drive_io_sequencer_i (.*);
  host_model host_model_i (.aclk(aclk), .want(want), .pins(pins));
  // Register write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa = 1, pw = 1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    while (pa || pw) begin
      @(negedge aclk);
      pa &= !s_axi_awready;
      pw &= !s_axi_wready;
      @(posedge aclk);
      s_axi_awvalid <= pa;
      s_axi_wvalid  <= pw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
  endtask
  // Register read
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Apply pin levels, wait out host and synchroniser latency
  task automatic go();
    want <= p;
    repeat (10) @(posedge aclk);
  endtask
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
  // Reset values, unmapped place, enable and fault
  task automatic t_basic();
    rdr(ADDR_TQ_LIMIT);
    chk("tq_limit", {16'h0, RST_TQ_LIMIT}, rd);
    rdr(8'h20);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs});
    p.main_power = 1;
    p.fwd_limit = 1;
    p.servo_enable = 1;
    go();
    chk("ready", 1, drive_ready_out);
    chk("energise", 1, motor_energise_out);
    chk("brake", 1, holding_brake_release_out);
    chk("fwd_inhibit", 0, fwd_inhibit_out);
    chk("rev_inhibit", 1, rev_inhibit_out);
    p.fault_event = 1;
    go();
    chk("fault_ok", 0, fault_ok_out);
    chk("ready_flt", 0, drive_ready_out);
    chk("irq_masked", 0, irq_out);
    wr(ADDR_IRQ_EN, 32'h1);
    chk("irq", 1, irq_out);
    p.servo_enable = 0;
    p.fault_clear = 1;
    p.fault_event = 0;
    go();
    chk("brake_off", 0, holding_brake_release_out);
    chk("fault_clr", 1, fault_ok_out);
    wr(ADDR_IRQ_CLR, 32'h1);
    chk("irq_clr", 0, irq_out);
  endtask
  // Pole estimation, torque cap, pulses, limits, deviation clear, homing
  task automatic t_motion();
    wr(ADDR_CONFIG, 32'h0000_0035);
    wr(ADDR_TQ_LIMIT, 32'h0000_0100);
    wr(ADDR_IN_POS, 32'h0000_0000);
    torque_cmd_in <= 16'h0200;
    p.fault_clear = 0;
    p.servo_enable = 1;
    p.torque_cap = 1;
    p.rev_limit = 1;
    p.pulse_gate = 1;
    go();
    chk("pole_est", 1, pole_estimating_out);
    go();
    chk("pole_done", 0, pole_estimating_out);
    chk("tq_cap", 32'h100, torque_cmd_out);
    chk("mon1", 32'h100, monitor_channel_one);
    p.pulse_a = 1;
    go();
    chk("cmd_step", 1, cmd_pos_out);
    chk("mon2", 1, monitor_channel_two);
    chk("unsettled", 0, settled_out);
    p.pulse_a = 0;
    p.fwd_limit = 0;
    go();
    p.pulse_a = 1;
    go();
    chk("fwd_block", 1, cmd_pos_out);
    p.pulse_a = 0;
    p.fwd_limit = 1;
    p.pulse_gate = 0;
    go();
    p.pulse_a = 1;
    go();
    chk("gate_off", 1, cmd_pos_out);
    p.deviation_clear = 1;
    p.homing_request = 1;
    go();
    chk("dev_clear", 0, cmd_pos_out);
    chk("settled", 1, settled_out);
    chk("seek", 1, home_seek_out);
    p.home_switch = 1;
    go();
    chk("homed", 1, homing_done_out);
    p.servo_enable = 0;
    go();
    chk("released", 0, motor_energise_out);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_basic();
    t_motion();
    end_sim();
  end
endmodule
